// [hdl/pcd_port.sv]
`timescale 1ns/10ps
module pcd_port (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cyc_end,
    input  wire logic       acc_c,
    input  wire logic       acc_d,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_op,
    input  wire logic [2:0] bit_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic       dir_wr_c,
    input  wire logic       dir_wr_d,
    input  wire logic [7:0] dir_data,
    input  wire logic       pullup_disable,
    input  wire logic       ref_a_output_enable,
    input  wire logic       ref_b_output_enable,
    input  wire logic       serial_enable,
    input  wire logic       comp_b_out,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    input  wire logic       scl_out,
    input  wire logic       scl_oe,
    input  wire logic [7:0] port_c_in,
    input  wire logic [7:0] port_d_in,
    output logic [7:0]      port_c_data,
    output logic [7:0]      port_d_data,
    output logic [7:0]      port_c_out,
    output logic [7:0]      port_c_oe,
    output logic [7:0]      port_d_out,
    output logic [7:0]      port_d_oe,
    output logic            port_c_pin_0_pullup,
    output logic            port_c_pin_0_analog,
    output logic            port_d_pin_3_ref_b,
    output logic            port_d_pin_2_comp_b,
    output logic            port_d_serial,
    output logic [7:0]      port_c_direction,
    output logic [7:0]      port_d_direction,
    output logic [7:0]      port_c_latch,
    output logic [7:0]      port_d_latch
);

    // ==========================================================
    // Pin synchronisers
    logic [7:0] c_meta;
    logic [7:0] d_meta;
    logic [7:0] c_sync;
    logic [7:0] d_sync;

    always_ff @(posedge clk) begin
        c_meta <= port_c_in;
        d_meta <= port_d_in;
        c_sync <= c_meta;
        d_sync <= d_meta;
    end

    // ==========================================================
    // Merge of a bit op with the sampled pins, or the whole write byte
    function automatic logic [7:0] pcd_merge(input logic [1:0] op,
                                             input logic [2:0] sel,
                                             input logic [7:0] wdat,
                                             input logic [7:0] pins);
        logic [7:0] res;
        res = pins;
        unique case (op)
            pcd_pkg::PCD_OP_BIT_SET:   res[sel] = 1'b1;
            pcd_pkg::PCD_OP_BIT_CLEAR: res[sel] = 1'b0;
            default:                   res = wdat;
        endcase
        return res;
    endfunction

    // ==========================================================
    // Latches, directions and the read snapshot
    logic [7:0] next_c_lat;
    logic [7:0] next_d_lat;
    logic [7:0] next_c_dir;
    logic [7:0] next_d_dir;
    logic [7:0] next_c_rd;
    logic [7:0] next_d_rd;

    always_comb begin
        next_c_lat = port_c_latch;
        next_d_lat = port_d_latch;
        next_c_dir = port_c_direction;
        next_d_dir = port_d_direction;
        next_c_rd  = port_c_data;
        next_d_rd  = port_d_data;
        if (!cyc_end) begin
            next_c_rd = c_sync;
            next_d_rd = d_sync;
        end
        if (cyc_end && wr_en && acc_c) begin
            next_c_lat = pcd_merge(wr_op, bit_sel, wr_data, port_c_data);
        end
        if (cyc_end && wr_en && acc_d) begin
            next_d_lat = pcd_merge(wr_op, bit_sel, wr_data, port_d_data);
        end
        if (cyc_end && dir_wr_c) begin
            next_c_dir = dir_data;
        end
        if (cyc_end && dir_wr_d) begin
            next_d_dir = dir_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_c_latch     <= pcd_pkg::LATCH_RESET;
            port_d_latch     <= pcd_pkg::LATCH_RESET;
            port_c_direction <= pcd_pkg::DIR_RESET;
            port_d_direction <= pcd_pkg::DIR_RESET;
            port_c_data      <= pcd_pkg::LATCH_RESET;
            port_d_data      <= pcd_pkg::LATCH_RESET;
        end else begin
            port_c_latch     <= next_c_lat;
            port_d_latch     <= next_d_lat;
            port_c_direction <= next_c_dir;
            port_d_direction <= next_d_dir;
            port_c_data      <= next_c_rd;
            port_d_data      <= next_d_rd;
        end
    end

    // ==========================================================
    // Pin drive and alternate functions
    logic [7:0] next_c_out;
    logic [7:0] next_c_oe;
    logic [7:0] next_d_out;
    logic [7:0] next_d_oe;
    logic       next_pullup;
    logic       next_analog;
    logic       next_ref_b;

    always_comb begin
        next_c_out  = next_c_lat;
        next_c_oe   = ~next_c_dir;
        next_d_out  = next_d_lat;
        next_d_oe   = ~next_d_dir;
        next_analog = ref_a_output_enable;
        next_ref_b  = ref_b_output_enable;
        next_pullup = next_c_dir[pcd_pkg::PC_REF_A_BIT] && !pullup_disable
                      && !ref_a_output_enable;
        if (ref_a_output_enable) begin
            next_c_oe[pcd_pkg::PC_REF_A_BIT] = 1'b0;
        end
        if (ref_b_output_enable) begin
            next_d_oe[pcd_pkg::PD_REF_B_BIT]  = 1'b0;
            next_d_out[pcd_pkg::PD_REF_B_BIT] = 1'b0;
            next_d_oe[pcd_pkg::PD_CMP_B_BIT]  = 1'b1;
            next_d_out[pcd_pkg::PD_CMP_B_BIT] = comp_b_out;
        end
        if (serial_enable) begin
            next_d_out[pcd_pkg::PD_SDA_BIT] = sda_out;
            next_d_oe[pcd_pkg::PD_SDA_BIT]  = sda_oe;
            next_d_out[pcd_pkg::PD_SCL_BIT] = scl_out;
            next_d_oe[pcd_pkg::PD_SCL_BIT]  = scl_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_c_out          <= pcd_pkg::LATCH_RESET;
            port_c_oe           <= pcd_pkg::LATCH_RESET;
            port_d_out          <= pcd_pkg::LATCH_RESET;
            port_d_oe           <= pcd_pkg::LATCH_RESET;
            port_c_pin_0_pullup <= 1'b0;
            port_c_pin_0_analog <= 1'b0;
            port_d_pin_3_ref_b  <= 1'b0;
            port_d_pin_2_comp_b <= 1'b0;
            port_d_serial       <= 1'b0;
        end else begin
            port_c_out          <= next_c_out;
            port_c_oe           <= next_c_oe;
            port_d_out          <= next_d_out;
            port_d_oe           <= next_d_oe;
            port_c_pin_0_pullup <= next_pullup;
            port_c_pin_0_analog <= next_analog;
            port_d_pin_3_ref_b  <= next_ref_b;
            port_d_pin_2_comp_b <= next_ref_b;
            port_d_serial       <= serial_enable;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pullup_on_cond: assert property (
        ##1 ($past(rst_n) && port_c_direction[0] && !$past(pullup_disable)
             && !$past(ref_a_output_enable)) |-> port_c_pin_0_pullup)
        else $error("Pull-up missing on input pin");
    a_pullup_off_dis: assert property (
        ##1 $past(pullup_disable) |-> !port_c_pin_0_pullup)
        else $error("Pull-up on while disabled");
    a_c0_output_drive: assert property (
        ##1 (!port_c_direction[0] && !$past(ref_a_output_enable))
        |-> (port_c_oe[0] && port_c_out[0] == port_c_latch[0]))
        else $error("Pin c0 not driving latch");
    a_ref_a_analog: assert property (
        ref_a_output_enable |=> (port_c_pin_0_analog && !port_c_oe[0] && !port_c_pin_0_pullup))
        else $error("Ref A mode wrong");
    a_ref_b_override: assert property (
        (ref_b_output_enable && comp_b_out) |=>
        (!port_d_oe[3] && port_d_oe[2] && port_d_out[2]))
        else $error("Ref B override wrong");
    a_serial_takeover: assert property (
        (serial_enable && scl_oe && !scl_out) |=> (port_d_oe[0] && !port_d_out[0]))
        else $error("Serial clock not passed");
    a_dir_input_hiz: assert property (
        ##1 (port_d_direction[7]) |-> !port_d_oe[7])
        else $error("Input pin driven");
    a_dir_reset_ones: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |=> port_d_direction == pcd_pkg::DIR_RESET)
        else $error("Direction reset wrong");
    a_read_pins: assert property (
        (rst_n && !cyc_end ##1 1) |-> ##0 port_d_data == $past(d_sync))
        else $error("Read not pin level");
    a_write_latch: assert property (
        (cyc_end && wr_en && acc_d && wr_op == 2'(pcd_pkg::PCD_OP_WRITE))
        |=> port_d_latch == $past(wr_data))
        else $error("Write not latched");
    a_bitset_rmw: assert property (
        (cyc_end && wr_en && acc_c && !acc_d && wr_op == 2'(pcd_pkg::PCD_OP_BIT_SET)
         && bit_sel == 3'h7) |=> port_c_latch == {1'b1, $past(port_c_data[6:0])})
        else $error("Bit set rmw wrong");
    a_read_hold_end: assert property (
        cyc_end |=> $stable(port_c_data))
        else $error("Read moved at cycle end");

    // ==========================================================
    // Refused requests, directions and alternate drive
    a_c_write_latch: assert property (
        (rst_n && cyc_end && wr_en && acc_c && wr_op == 2'(pcd_pkg::PCD_OP_WRITE))
        |=> port_c_latch == $past(wr_data))
        else $error("Port c write not latched");
    a_write_refused: assert property (
        (rst_n && !cyc_end)
        |=> ($stable(port_c_latch) && $stable(port_d_latch)))
        else $error("Latch moved outside cycle end");
    a_bitclr_rmw: assert property (
        (rst_n && cyc_end && wr_en && acc_d && wr_op == 2'(pcd_pkg::PCD_OP_BIT_CLEAR)
         && bit_sel == 3'h0) |=> port_d_latch == {$past(port_d_data[7:1]), 1'b0})
        else $error("Bit clear rmw wrong");
    a_dir_c_write: assert property (
        (rst_n && cyc_end && dir_wr_c)
        |=> port_c_direction == $past(dir_data))
        else $error("Port c direction not written");
    a_dir_d_write: assert property (
        (rst_n && cyc_end && dir_wr_d)
        |=> port_d_direction == $past(dir_data))
        else $error("Port d direction not written");
    a_dir_hold: assert property (
        (rst_n && !cyc_end)
        |=> ($stable(port_c_direction) && $stable(port_d_direction)))
        else $error("Direction moved outside cycle end");
    a_ref_b_low: assert property (
        (rst_n && ref_b_output_enable && !comp_b_out) |=> (port_d_pin_3_ref_b
         && port_d_pin_2_comp_b && port_d_oe[2] && !port_d_out[2]))
        else $error("Ref B low output wrong");
    a_serial_data: assert property (
        (rst_n && serial_enable) |=> (port_d_serial && port_d_oe[1] == $past(sda_oe)
         && port_d_out[1] == $past(sda_out)))
        else $error("Serial data not passed");
    a_d_output_drive: assert property (
        ##1 ($past(rst_n) && !$past(ref_b_output_enable) && !$past(serial_enable))
        |-> (port_d_oe == ~port_d_direction && port_d_out == port_d_latch))
        else $error("Port d drive not from latch");
    a_c0_input_hiz: assert property (
        ##1 ($past(rst_n) && port_c_direction[0]) |-> !port_c_oe[0])
        else $error("Input pin c0 driven");
    a_pullup_off_out: assert property (
        ##1 (!port_c_direction[0]) |-> !port_c_pin_0_pullup)
        else $error("Pull-up on output pin");
    a_read_c_pins: assert property (
        (rst_n && !cyc_end ##1 1) |-> ##0 port_c_data == $past(c_sync))
        else $error("Port c read not pin level");
    a_read_d_hold: assert property (
        (rst_n && cyc_end) |=> $stable(port_d_data))
        else $error("Port d read moved at cycle end");

    c_write_d: cover property (cyc_end && wr_en && acc_d);
    c_bit_clear: cover property (cyc_end && wr_en && acc_c
                                 && wr_op == 2'(pcd_pkg::PCD_OP_BIT_CLEAR));
    c_ref_b_mode: cover property (ref_b_output_enable ##1 port_d_pin_3_ref_b);
    c_serial_mode: cover property (serial_enable ##1 port_d_serial);
    c_c0_analog: cover property (ref_a_output_enable ##1 port_c_pin_0_analog);

endmodule

// [hdl/pcd_pkg.sv]
package pcd_pkg;
    // ==========================================================
    // Widths and reset values
    localparam int          PORT_W       = 8;
    localparam logic [7:0]  DIR_RESET    = 8'hFF;
    localparam logic [7:0]  LATCH_RESET  = 8'h00;
    // ==========================================================
    // Pin positions with alternate functions
    localparam int          PC_REF_A_BIT = 0;
    localparam int          PD_REF_B_BIT = 3;
    localparam int          PD_CMP_B_BIT = 2;
    localparam int          PD_SDA_BIT   = 1;
    localparam int          PD_SCL_BIT   = 0;
    // ==========================================================
    // Port access operations
    typedef enum logic [1:0] {
        PCD_OP_WRITE,
        PCD_OP_BIT_SET,
        PCD_OP_BIT_CLEAR
    } pcd_op_e;
endpackage

// [test/pcd_pin_model.sv]
`timescale 1ns/10ps
// ==========================================
// Far side of the pins: a driven bit shows the port, any other bit shows the outside level
module pcd_pin_model (
    input  wire logic [7:0] c_out,
    input  wire logic [7:0] c_oe,
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe,
    input  wire logic [7:0] c_ext,
    input  wire logic [7:0] d_ext,
    output logic [7:0]      c_pin,
    output logic [7:0]      d_pin
);
    assign c_pin = (c_oe & c_out) | (~c_oe & c_ext);
    assign d_pin = (d_oe & d_out) | (~d_oe & d_ext);
endmodule

// [test/port_c_d_pin_control_tb.sv]
`timescale 1ns/10ps
module port_c_d_pin_control_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc_end, acc_c, acc_d, wr_en, dir_wr_c, dir_wr_d;
    logic        pullup_disable, ref_a_output_enable, ref_b_output_enable, serial_enable;
    logic        comp_b_out, sda_out, sda_oe, scl_out, scl_oe;
    logic [1:0]  wr_op;
    logic [2:0]  bit_sel;
    logic [7:0]  wr_data, dir_data, port_c_in, port_d_in, c_ext, d_ext;
    logic [7:0]  port_c_data, port_d_data, port_c_out, port_c_oe, port_d_out, port_d_oe;
    logic [7:0]  port_c_direction, port_d_direction, port_c_latch, port_d_latch;
    logic        port_c_pin_0_pullup, port_c_pin_0_analog;
    logic        port_d_pin_3_ref_b, port_d_pin_2_comp_b, port_d_serial;
    logic [31:0] seed = 32'h5832_eb98;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #50 clk = ~clk;

    pcd_port dut_u (.clk, .rst_n, .cyc_end, .acc_c, .acc_d, .wr_en, .wr_op, .bit_sel, .wr_data,
        .dir_wr_c, .dir_wr_d, .dir_data, .pullup_disable, .ref_a_output_enable,
        .ref_b_output_enable, .serial_enable, .comp_b_out, .sda_out, .sda_oe, .scl_out, .scl_oe,
        .port_c_in, .port_d_in, .port_c_data, .port_d_data, .port_c_out, .port_c_oe,
        .port_d_out, .port_d_oe, .port_c_pin_0_pullup, .port_c_pin_0_analog,
        .port_d_pin_3_ref_b, .port_d_pin_2_comp_b, .port_d_serial, .port_c_direction,
        .port_d_direction, .port_c_latch, .port_d_latch);

    pcd_pin_model pins_u (.c_out(port_c_out), .c_oe(port_c_oe), .d_out(port_d_out),
        .d_oe(port_d_oe), .c_ext(c_ext), .d_ext(d_ext), .c_pin(port_c_in), .d_pin(port_d_in));

    // ==========================================
    // Helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [7:0] pick(input logic p, input logic [7:0] c, input logic [7:0] d);
        return p ? d : c;
    endfunction

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Strobes are {acc_c, acc_d, wr_en, dir_wr_c, dir_wr_d}
    task op(input logic ce, input logic [4:0] st, input logic [1:0] o, input logic [2:0] b,
            input logic [7:0] d);
        @(posedge clk);
        {acc_c, acc_d, wr_en, dir_wr_c, dir_wr_d} <= st;
        cyc_end <= ce;
        wr_op <= o;
        bit_sel <= b;
        wr_data <= d;
        dir_data <= d;
        @(posedge clk);
        {acc_c, acc_d, wr_en, dir_wr_c, dir_wr_d} <= 5'h00;
        cyc_end <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0]  lat, dir, pins, e8, g8;
        logic [31:0] r;
        logic        p;
        {cyc_end, acc_c, acc_d, wr_en, dir_wr_c, dir_wr_d, wr_op, bit_sel} = '0;
        {pullup_disable, ref_a_output_enable, ref_b_output_enable, serial_enable} = '0;
        {comp_b_out, sda_out, sda_oe, scl_out, scl_oe} = '0;
        {wr_data, dir_data, c_ext, d_ext} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("dir_d_rst", 8'hFF, port_d_direction);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            p = r[0];
            @(posedge clk);
            c_ext <= r[15:8];
            d_ext <= r[23:16];
            pullup_disable <= r[1];
            lat = 8'(rnd());
            dir = 8'(rnd());
            op(1'b1, p ? 5'b01100 : 5'b10100, 2'h0, 3'h0, lat);
            chk("latch", lat, pick(p, port_c_latch, port_d_latch));
            op(1'b1, p ? 5'b00001 : 5'b00010, 2'h0, 3'h0, dir);
            chk("dir", dir, pick(p, port_c_direction, port_d_direction));
            chk("oe", ~dir, pick(p, port_c_oe, port_d_oe));
            chk("out", lat & ~dir, pick(p, port_c_out, port_d_out) & ~dir);
            pins = (lat & ~dir) | (pick(p, r[15:8], r[23:16]) & dir);
            chk("read", pins, pick(p, port_c_data, port_d_data));
            r = rnd();
            op(1'b1, p ? 5'b01100 : 5'b10100,
               r[3] ? pcd_pkg::PCD_OP_BIT_SET : pcd_pkg::PCD_OP_BIT_CLEAR, r[2:0], r[15:8]);
            lat = pins;
            lat[r[2:0]] = r[3];
            chk("rmw", lat, pick(p, port_c_latch, port_d_latch));
            op(1'b0, p ? 5'b01100 : 5'b10100, 2'h0, 3'h0, ~lat);
            chk("no_end", lat, pick(p, port_c_latch, port_d_latch));
        end
        r = rnd();
        @(posedge clk);
        ref_b_output_enable <= 1'b1;
        comp_b_out <= r[0];
        op(1'b1, 5'b00001, 2'h0, 3'h0, 8'h00);
        chk("refb_oe", 8'h04, port_d_oe & 8'h0C);
        chk("refb_out", {5'h00, r[0], 2'h0}, port_d_out & 8'h04);
        chk("refb_mode", 8'h03, {6'h00, port_d_pin_3_ref_b, port_d_pin_2_comp_b});
        @(posedge clk);
        ref_b_output_enable <= 1'b0;
        serial_enable <= 1'b1;
        scl_oe <= 1'b1;
        scl_out <= r[1];
        op(1'b0, 5'h00, 2'h0, 3'h0, 8'h00);
        chk("ser_oe", 8'h01, port_d_oe & 8'h03);
        chk("ser_out", {7'h00, r[1]}, port_d_out & 8'h01);
        chk("ser_mode", 8'h01, {7'h00, port_d_serial});
        for (int j = 0; j < 8; j++) begin
            if (!(j[2] && j[0])) begin
                @(posedge clk);
                pullup_disable <= j[1];
                ref_a_output_enable <= j[0];
                op(1'b1, 5'b00010, 2'h0, 3'h0, {7'h00, j[2]});
                e8 = {5'h00, j[2] & ~j[1] & ~j[0], j[0], ~j[2] & ~j[0]};
                g8 = {5'h00, port_c_pin_0_pullup, port_c_pin_0_analog, port_c_oe[0]};
                chk("c0_mode", e8, g8);
            end
        end
        summarize();
    end
endmodule
